// >>> core/ccg_config_regs.sv
`timescale 1ns/10ps

module ccg_config_regs (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire ccg_pkg::ccg_req_type req_i,
    input wire logic [2:0] strap_freq_i,
    input wire logic strap_memfreq_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output ccg_pkg::ccg_mode_type mode_o,
    output ccg_pkg::ccg_enables_type enables_o
);
    import ccg_pkg::*;

    function automatic logic [7:0] ccg_wmask(input logic [2:0] addr);
        unique case (addr)
            CCG_OFS_FREQ_FUNC: ccg_wmask = CCG_WMASK_FREQ_FUNC;
            CCG_OFS_CPU_EN: ccg_wmask = CCG_WMASK_CPU_EN;
            CCG_OFS_PCI_EN: ccg_wmask = CCG_WMASK_PCI_EN;
            CCG_OFS_MEM_EN_LO: ccg_wmask = CCG_WMASK_MEM_EN_LO;
            CCG_OFS_MEM_MISC_EN: ccg_wmask = CCG_WMASK_MEM_MISC_EN;
            CCG_OFS_PERIPH_EN: ccg_wmask = CCG_WMASK_PERIPH_EN;
            default: ccg_wmask = 8'h00;
        endcase
    endfunction

    logic [7:0] cfg [CCG_NUM_REGS];
    logic [7:0] next_cfg [CCG_NUM_REGS];
    logic freq_written;
    logic next_freq_written;
    logic [3:0] strap_meta;
    logic [3:0] strap_sync;
    logic [3:0] strap_latch;
    logic [3:0] next_strap_latch;
    logic [1:0] strap_cnt;
    logic [1:0] next_strap_cnt;
    logic [7:0] next_rdata;
    logic next_rvalid;
    ccg_mode_type next_mode;
    ccg_enables_type next_enables;

    // Register writes and the frequency-field ownership flag
    always_comb begin
        for (int i = 0; i < CCG_NUM_REGS; i++) begin
            next_cfg[i] = cfg[i];
        end
        next_freq_written = freq_written;
        if (req_i.wr && (ccg_wmask(req_i.addr) != 8'h00)) begin
            next_cfg[req_i.addr] = (cfg[req_i.addr] & ~ccg_wmask(req_i.addr))
                | (req_i.wdata & ccg_wmask(req_i.addr));
            if (req_i.addr == CCG_OFS_FREQ_FUNC) begin
                next_freq_written = 1'b1;
            end
        end
    end

    // Straps are caught once, after the two-flop synchroniser has settled
    // A pin that moves after the latch is ignored until the next reset
    always_comb begin
        next_strap_latch = strap_latch;
        next_strap_cnt = strap_cnt;
        if (strap_cnt != CCG_STRAP_WAIT + 2'h1) begin
            next_strap_cnt = strap_cnt + 2'h1;
            if (strap_cnt == CCG_STRAP_WAIT) begin
                next_strap_latch = strap_sync;
            end
        end
    end

    // Read data: enable bits, reserved ones, inverted strap readbacks
    // A read and a write in one cycle return the byte as it was before the write
    always_comb begin
        next_rdata = 8'h00;
        next_rvalid = req_i.rd;
        if (req_i.rd) begin
            unique case (req_i.addr)
                CCG_OFS_FREQ_FUNC: begin
                    next_rdata = cfg[CCG_OFS_FREQ_FUNC];
                    if (!freq_written) begin
                        next_rdata[CCG_BIT_CODE_MSB] = CCG_REV_ID[3];
                        next_rdata[CCG_BIT_CODE_LO +: 3] = CCG_REV_ID[2:0];
                    end
                end
                CCG_OFS_CPU_EN: begin
                    next_rdata = cfg[CCG_OFS_CPU_EN];
                    next_rdata[CCG_BIT_FS0_RB] = ~strap_latch[0];
                end
                CCG_OFS_PCI_EN: begin
                    next_rdata = cfg[CCG_OFS_PCI_EN];
                    next_rdata[CCG_BIT_FS1_RB] = ~strap_latch[1];
                end
                CCG_OFS_MEM_EN_LO: next_rdata = cfg[CCG_OFS_MEM_EN_LO];
                CCG_OFS_MEM_MISC_EN: next_rdata = cfg[CCG_OFS_MEM_MISC_EN];
                CCG_OFS_PERIPH_EN: begin
                    next_rdata = cfg[CCG_OFS_PERIPH_EN];
                    next_rdata[CCG_BIT_FS2_RB] = ~strap_latch[2];
                    next_rdata[CCG_BIT_MEMSEL_RB] = ~strap_latch[3];
                end
                // Unmapped offsets answer with zero rather than stall the host
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Mode and per-output run enables follow the new register contents at once
    always_comb begin
        next_mode.outputs_tristate = next_cfg[CCG_OFS_FREQ_FUNC][CCG_BIT_TRISTATE];
        next_mode.spread_en = next_cfg[CCG_OFS_FREQ_FUNC][CCG_BIT_SPREAD_EN];
        next_mode.spread_down = next_cfg[CCG_OFS_FREQ_FUNC][CCG_BIT_SPREAD_DOWN];
        if (next_cfg[CCG_OFS_FREQ_FUNC][CCG_BIT_SW_SELECT]) begin
            next_mode.freq_code = {next_cfg[CCG_OFS_FREQ_FUNC][CCG_BIT_CODE_MSB],
                next_cfg[CCG_OFS_FREQ_FUNC][CCG_BIT_CODE_LO +: 3]};
        end else begin
            next_mode.freq_code = next_strap_latch;
        end
        // Top code bit is the memory column choice in either mode
        next_mode.mem_follow_cpu = next_mode.freq_code[3];
    end

    // Tristate leaves these alone; the pad stage combines both
    always_comb begin
        // A zero enable parks the output low; the clock driver uses these as gates
        next_enables.processor_clock_out = next_cfg[CCG_OFS_CPU_EN][3:1];
        next_enables.free_running_periph_clock = next_cfg[CCG_OFS_PCI_EN][6];
        next_enables.periph_bus_clock = next_cfg[CCG_OFS_PCI_EN][4:0];
        next_enables.memory_clock_out = {next_cfg[CCG_OFS_MEM_MISC_EN][4:0],
            next_cfg[CCG_OFS_MEM_EN_LO]};
        next_enables.superio_clock_out = next_cfg[CCG_OFS_MEM_MISC_EN][6];
        next_enables.usb48_clock_out = next_cfg[CCG_OFS_MEM_MISC_EN][5];
        next_enables.interrupt_ctrl_clock = next_cfg[CCG_OFS_PERIPH_EN][4];
        next_enables.reference_out = next_cfg[CCG_OFS_PERIPH_EN][2:0];
    end

    // Bank and frequency-field ownership flag
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg[0] <= CCG_RST_FREQ_FUNC;
            for (int i = 1; i < CCG_NUM_REGS; i++) begin
                cfg[i] <= CCG_RST_ENABLES;
            end
            freq_written <= 1'b0;
        end else begin
            for (int i = 0; i < CCG_NUM_REGS; i++) begin
                cfg[i] <= next_cfg[i];
            end
            freq_written <= next_freq_written;
        end
    end

    // Two-flop synchroniser; only the second stage is read by logic
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_meta <= 4'h0;
            strap_sync <= 4'h0;
        end else begin
            strap_meta <= {strap_memfreq_i, strap_freq_i};
            strap_sync <= strap_meta;
        end
    end

    // One-time strap latch and its settling counter
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_latch <= 4'h0;
            strap_cnt <= 2'h0;
        end else begin
            strap_latch <= next_strap_latch;
            strap_cnt <= next_strap_cnt;
        end
    end

    // Read answer
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rdata_o <= next_rdata;
            rvalid_o <= next_rvalid;
        end
    end

    // Mode resets to what the power-up byte 0 selects, so spread type never glitches
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_o <= '{freq_code: 4'h0,
                mem_follow_cpu: 1'b0,
                spread_en: CCG_RST_FREQ_FUNC[CCG_BIT_SPREAD_EN],
                spread_down: CCG_RST_FREQ_FUNC[CCG_BIT_SPREAD_DOWN],
                outputs_tristate: CCG_RST_FREQ_FUNC[CCG_BIT_TRISTATE]};
        end else begin
            mode_o <= next_mode;
        end
    end

    // Run enables
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enables_o <= '1;
        end else begin
            enables_o <= next_enables;
        end
    end

endmodule

// >>> core/ccg_pkg.sv
package ccg_pkg;

    localparam int unsigned CCG_NUM_REGS = 6;

    // Register offsets
    localparam logic [2:0] CCG_OFS_FREQ_FUNC = 3'h0;
    localparam logic [2:0] CCG_OFS_CPU_EN = 3'h1;
    localparam logic [2:0] CCG_OFS_PCI_EN = 3'h2;
    localparam logic [2:0] CCG_OFS_MEM_EN_LO = 3'h3;
    localparam logic [2:0] CCG_OFS_MEM_MISC_EN = 3'h4;
    localparam logic [2:0] CCG_OFS_PERIPH_EN = 3'h5;

    // Power-up values
    localparam logic [7:0] CCG_RST_FREQ_FUNC = 8'h80;
    localparam logic [7:0] CCG_RST_ENABLES = 8'hFF;

    // Software-writable bits; every other bit of an enable byte reads 1 or a strap
    localparam logic [7:0] CCG_WMASK_FREQ_FUNC = 8'hFF;
    localparam logic [7:0] CCG_WMASK_CPU_EN = 8'h0E;
    localparam logic [7:0] CCG_WMASK_PCI_EN = 8'h5F;
    localparam logic [7:0] CCG_WMASK_MEM_EN_LO = 8'hFF;
    localparam logic [7:0] CCG_WMASK_MEM_MISC_EN = 8'h7F;
    localparam logic [7:0] CCG_WMASK_PERIPH_EN = 8'h17;

    // Field positions in the frequency/function byte
    localparam int unsigned CCG_BIT_TRISTATE = 0;
    localparam int unsigned CCG_BIT_SPREAD_EN = 1;
    localparam int unsigned CCG_BIT_CODE_MSB = 2;
    localparam int unsigned CCG_BIT_SW_SELECT = 3;
    localparam int unsigned CCG_BIT_CODE_LO = 4;
    localparam int unsigned CCG_BIT_SPREAD_DOWN = 7;

    // Strap readback positions
    localparam int unsigned CCG_BIT_FS0_RB = 0;
    localparam int unsigned CCG_BIT_FS1_RB = 7;
    localparam int unsigned CCG_BIT_FS2_RB = 6;
    localparam int unsigned CCG_BIT_MEMSEL_RB = 3;

    // Arbitrary revision value returned in the frequency field before it is written
    localparam logic [3:0] CCG_REV_ID = 4'h5;

    // Strap latch waits for the synchroniser to fill
    localparam logic [1:0] CCG_STRAP_WAIT = 2'h2;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } ccg_req_type;

    typedef struct packed {
        logic [3:1] processor_clock_out;
        logic free_running_periph_clock;
        logic [4:0] periph_bus_clock;
        logic [12:0] memory_clock_out;
        logic superio_clock_out;
        logic usb48_clock_out;
        logic interrupt_ctrl_clock;
        logic [2:0] reference_out;
    } ccg_enables_type;

    typedef struct packed {
        logic [3:0] freq_code;
        logic mem_follow_cpu;
        logic spread_en;
        logic spread_down;
        logic outputs_tristate;
    } ccg_mode_type;

endpackage

// >>> test/ccg_host_model.sv
`timescale 1ns/10ps
module ccg_host_model (
    input wire logic clk_i,
    output ccg_pkg::ccg_req_type req_o,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i
);
    import ccg_pkg::*;
    initial req_o = '0;
    // One strobe per transfer; the taking rising edge sits between two falling edges
    task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic v);
        @(negedge clk_i);
        req_o = '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(negedge clk_i);
        req_o.wr = 1'b0;
        req_o.rd = 1'b0;
        // Released data is not left looking valid
        req_o.wdata = ~d;
        q = rdata_i;
        v = rvalid_i;
    endtask
endmodule

// >>> test/ccg_config_regs_assertions.sv
`timescale 1ns/10ps
module ccg_config_regs_checker (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire ccg_pkg::ccg_req_type req_i,
    input wire logic [2:0] strap_freq_i,
    input wire logic strap_memfreq_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire ccg_pkg::ccg_mode_type mode_o,
    input wire ccg_pkg::ccg_enables_type enables_o
);
    import ccg_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_rd_ans; req_i.rd |=> rvalid_o; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_no_ans; !req_i.rd |=> !rvalid_o; endproperty
    a_no_ans: assert property (p_no_ans) else $error("answer without read");
    property p_unmapped; req_i.rd && req_i.addr > 3'h5 |=> rdata_o == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_cpu_en; req_i.wr && req_i.addr == 3'h1
        |=> enables_o.processor_clock_out == $past(req_i.wdata[3:1]); endproperty
    a_cpu_en: assert property (p_cpu_en) else $error("cpu enables wrong");
    property p_mem_lo; req_i.wr && req_i.addr == 3'h3
        |=> enables_o.memory_clock_out[7:0] == $past(req_i.wdata); endproperty
    a_mem_lo: assert property (p_mem_lo) else $error("memory enables wrong");
    property p_func; req_i.wr && req_i.addr == 3'h0 |=> {mode_o.spread_down,
        mode_o.spread_en, mode_o.outputs_tristate} == $past({req_i.wdata[7], req_i.wdata[1:0]});
    endproperty
    a_func: assert property (p_func) else $error("function bits wrong");
    property p_sw_code; req_i.wr && req_i.addr == 3'h0 && req_i.wdata[3]
        |=> mode_o.freq_code == $past({req_i.wdata[2], req_i.wdata[6:4]}); endproperty
    a_sw_code: assert property (p_sw_code) else $error("software code wrong");
    // Tracks the frequency source and the last read offset from the host's own requests
    logic sw_sel_q;
    logic [2:0] rd_addr_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sw_sel_q <= CCG_RST_FREQ_FUNC[CCG_BIT_SW_SELECT];
            rd_addr_q <= 3'h0;
        end else begin
            if (req_i.wr && req_i.addr == 3'h0) begin
                sw_sel_q <= req_i.wdata[3];
            end
            if (req_i.rd) begin
                rd_addr_q <= req_i.addr;
            end
        end
    end
    property p_follow; rvalid_o && rd_addr_q == 3'h5 && !sw_sel_q
        |-> mode_o.mem_follow_cpu == !rdata_o[3]; endproperty
    a_follow: assert property (p_follow) else $error("memory follow wrong");
    property p_hold; !req_i.wr |=> $stable(enables_o); endproperty
    a_hold: assert property (p_hold) else $error("enables moved without write");
endmodule
bind ccg_config_regs ccg_config_regs_checker u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .req_i(req_i), .strap_freq_i(strap_freq_i), .strap_memfreq_i(strap_memfreq_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .mode_o(mode_o), .enables_o(enables_o));

// >>> test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import ccg_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [2:0] strap_freq_i = 3'h5;
    logic strap_memfreq_i = 1'b0;
    ccg_req_type req_i;
    logic [7:0] rdata_o;
    logic rvalid_o;
    ccg_mode_type mode_o;
    ccg_enables_type enables_o;
    int fails = 0;
    int n_tests = 0;
    logic [7:0] q;
    logic v;
    // Straps 101, memory strap 0; frequency field reads as the revision code
    logic [7:0] rst_val [6] = '{8'hD0, 8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'hBF};
    logic [7:0] zero_val [6] = '{8'h00, 8'hF0, 8'hA0, 8'h00, 8'h80, 8'hA8};
    always #5 clk_i = ~clk_i;
    ccg_config_regs u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i),
        .strap_freq_i(strap_freq_i), .strap_memfreq_i(strap_memfreq_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .mode_o(mode_o), .enables_o(enables_o));
    ccg_host_model u_host (.clk_i(clk_i), .req_o(req_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_host.xfer(1'b1, a, d, q, v);
        check({7'h00, v}, 8'h00);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        u_host.xfer(1'b0, a, 8'h00, q, v);
        check({7'h00, v}, 8'h01);
        check(q, exp);
    endtask
    task automatic mode_is(input logic [3:0] code, input logic [2:0] fn);
        check({4'h0, mode_o.freq_code}, {4'h0, code});
        check({5'h00, mode_o.spread_down, mode_o.spread_en, mode_o.outputs_tristate},
              {5'h00, fn});
    endtask
    task automatic finish_test();
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (6) @(negedge clk_i);
        mode_is(4'h5, 3'h4);
        check({7'h00, &enables_o}, 8'h01);
        // Pins move after the latch; readback must keep the power-on values
        strap_freq_i = 3'h2;
        strap_memfreq_i = 1'b1;
        for (int i = 0; i < 6; i++) rd(i[2:0], rst_val[i]);
        for (int i = 0; i < 6; i++) wr(i[2:0], 8'h00);
        for (int i = 0; i < 6; i++) rd(i[2:0], zero_val[i]);
        check({7'h00, |enables_o}, 8'h00);
        mode_is(4'h5, 3'h0);
        // Distinct patterns catch swapped or shifted enable bits
        wr(3'h1, 8'h04);
        wr(3'h2, 8'h4A);
        wr(3'h3, 8'h5A);
        wr(3'h4, 8'h35);
        wr(3'h5, 8'h12);
        check({5'h00, enables_o.processor_clock_out}, 8'h02);
        check({2'h0, enables_o.free_running_periph_clock, enables_o.periph_bus_clock},
              8'h2A);
        check(enables_o.memory_clock_out[7:0], 8'h5A);
        check({3'h0, enables_o.memory_clock_out[12:8]}, 8'h15);
        check({6'h00, enables_o.superio_clock_out, enables_o.usb48_clock_out}, 8'h01);
        check({4'h0, enables_o.interrupt_ctrl_clock, enables_o.reference_out}, 8'h0A);
        for (int i = 1; i < 6; i++) wr(i[2:0], 8'hFF);
        for (int i = 1; i < 6; i++) rd(i[2:0], rst_val[i]);
        check({7'h00, &enables_o}, 8'h01);
        wr(3'h0, 8'h7A);
        rd(3'h0, 8'h7A);
        mode_is(4'h7, 3'h2);
        wr(3'h0, 8'hFC);
        mode_is(4'hF, 3'h4);
        check({7'h00, mode_o.mem_follow_cpu}, 8'h01);
        wr(3'h0, 8'h81);
        mode_is(4'h5, 3'h5);
        wr(3'h6, 8'h00);
        wr(3'h7, 8'h00);
        rd(3'h6, 8'h00);
        rd(3'h7, 8'h00);
        check({7'h00, &enables_o}, 8'h01);
        finish_test();
    end
    initial begin
        #20000;
        fails++;
        finish_test();
    end
endmodule
